// ==== uwa_pkg.sv ====
/*
 Shared constants and carrier types of the wake-source and bus-address block.
 Assumes a 20 MHz register clock and a register bus with 32-bit words.
*/
package uwa_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [7:0] FLAGS_IDX = 8'ha0;
	localparam logic [7:0] MASK_IDX = 8'ha6;
	localparam logic [7:0] ADDR_IDX = 8'ha9;
	localparam logic [7:0] CTRL_IDX = 8'hb0;
	localparam int PADDR_W = 10;

	// Wake flag and mask field positions
	localparam int BIT_EXT = 0;
	localparam int BIT_RESUME = 1;
	localparam int BIT_RESET = 2;

	// Reset values and fixed read bits
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'hff;
	localparam logic [7:0] MASK_FIXED = 8'hf8;
	localparam logic [7:0] ADDR_RESET = 8'h00;
	localparam logic [7:0] ADDR_FIXED = 8'h80;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Control register field positions
	localparam int CTRL_PD = 0;
	localparam int CTRL_SLEEP = 1;
	localparam int CTRL_SUSPEND = 2;
	localparam int CTRL_ADDR_EN = 3;
	localparam int CTRL_RING_ON = 4;
	localparam int CTRL_XTAL_ON = 5;

	// Bus-reset timing in bit times and the derived clock counts
	localparam int CLK_HZ = 20_000_000;
	localparam int FS_BIT_HZ = 12_000_000;
	localparam int LS_BIT_HZ = 1_500_000;
	localparam int FS_MIN_BITS = 32;
	localparam int FS_MAX_BITS = 64;
	localparam int LS_MIN_BITS = 4;
	localparam int LS_MAX_BITS = 8;
	localparam logic [6:0] FS_MIN_CYC = 7'((FS_MIN_BITS * CLK_HZ + FS_BIT_HZ - 1) / FS_BIT_HZ);
	localparam logic [6:0] FS_MAX_CYC = 7'((FS_MAX_BITS * CLK_HZ) / FS_BIT_HZ);
	localparam logic [6:0] LS_MIN_CYC = 7'((LS_MIN_BITS * CLK_HZ + LS_BIT_HZ - 1) / LS_BIT_HZ);
	localparam logic [6:0] LS_MAX_CYC = 7'((LS_MAX_BITS * CLK_HZ) / LS_BIT_HZ);

	// Bus data line pair
	typedef struct packed {
		logic dp;
		logic dm;
	} uwa_line_type;

	// Address load from the serial interface engine
	typedef struct packed {
		logic load;
		logic [6:0] value;
	} uwa_addr_load_type;

	// Oscillator enables toward the clock generator
	typedef struct packed {
		logic ring_en;
		logic xtal_en;
	} uwa_osc_type;
endpackage

// ==== uwa_line_detect.sv ====
/*
 Bus line watcher: single-ended-zero timer for bus reset and J-exit detect for resume.
 Assumes the line pair is already synchronous to pclk.
*/
`timescale 1ns/1ps
module uwa_line_detect (
	input wire logic pclk,
	input wire logic presetn,
	input wire uwa_pkg::uwa_line_type line,
	input wire logic low_speed,
	input wire logic suspend,
	output logic bus_reset_pulse,
	output logic resume_pulse
);
	logic se0;
	logic is_j;
	logic [6:0] min_cyc;
	logic [6:0] max_cyc;
	logic [6:0] run_q;
	logic prev_j_q;
	logic [6:0] chk_q;

	// Line state decode; J polarity depends on speed
	assign se0 = !line.dp && !line.dm;
	assign is_j = low_speed ? (!line.dp && line.dm) : (line.dp && !line.dm);
	assign min_cyc = low_speed ? uwa_pkg::LS_MIN_CYC : uwa_pkg::FS_MIN_CYC;
	assign max_cyc = low_speed ? uwa_pkg::LS_MAX_CYC : uwa_pkg::FS_MAX_CYC;

	// Single-ended-zero run length, saturating at the longest window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q <= 7'h00;
		end else if (!se0) begin
			run_q <= 7'h00;
		end else if (run_q != max_cyc) begin
			run_q <= run_q + 7'h01;
		end
	end

	// One pulse once the run reaches the shortest legal window
	assign bus_reset_pulse = se0 && (run_q == min_cyc - 7'h01);

	// Previous J state for the resume edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_j_q <= 1'b1;
		end else begin
			prev_j_q <= is_j;
		end
	end

	// Leaving J only counts while suspended
	assign resume_pulse = suspend && prev_j_q && !is_j;

	// Independent run counter for checking only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chk_q <= 7'h00;
		end else if (!se0) begin
			chk_q <= 7'h00;
		end else if (chk_q != 7'h7f) begin
			chk_q <= chk_q + 7'h01;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_reset_window: assert property ($stable(low_speed) |->
		(bus_reset_pulse == (se0 && chk_q == min_cyc - 7'h01)))
		else $error("bus reset pulse not at the shortest SE0 window");
	a_resume_edge: assert property (resume_pulse |-> suspend && $past(is_j) && !is_j)
		else $error("resume pulse without a J exit in suspend");
	c_bus_reset: cover property (bus_reset_pulse);
	c_resume: cover property (resume_pulse);
endmodule

// ==== uwa_wake_ctrl.sv ====
/*
 Wake-source flags, wake mask, bus address and oscillator stop/restart, behind APB.
 Assumes a zero-wait APB master on pclk and line, token and load inputs synchronous to pclk.
*/
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module uwa_wake_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [uwa_pkg::PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire uwa_pkg::uwa_line_type line,
	input wire logic low_speed,
	input wire logic disk_irq_flag,
	input wire logic gpio_irq_line,
	input wire uwa_pkg::uwa_addr_load_type addr_load,
	input wire logic token_valid,
	input wire logic [6:0] token_addr,
	output logic addr_match,
	output logic mcu_wake_irq_input,
	output uwa_pkg::uwa_osc_type osc,
	output logic xcvr_power_down
);
	typedef enum logic [1:0] {
		CLK_RUN,
		CLK_GATE_RING,
		CLK_STOPPED
	} uwa_clk_state_type;

	uwa_clk_state_type clk_state_q;
	logic [2:1] flags_q;
	logic [2:0] mask_q;
	logic [6:0] addr_q;
	logic pd_q;
	logic sleep_q;
	logic suspend_q;
	logic addr_en_q;
	logic [31:0] prdata_q;
	logic match_q;
	logic ext_bit;
	logic [2:0] unmasked;
	logic [2:1] flag_set;
	logic [2:1] flag_clr;
	logic bus_reset_pulse;
	logic resume_pulse;
	logic wr_en;
	logic mapped;
	logic wake_now;
	logic [31:0] rd_data;

	// Register hit for one index at its word address
	function automatic logic reg_hit(input logic [uwa_pkg::PADDR_W-1:0] a,
		input logic [7:0] idx);
		return a == {idx, 2'b00};
	endfunction

	// Line watcher for bus reset and resume
	uwa_line_detect u_detect (
		.pclk(pclk),
		.presetn(presetn),
		.line(line),
		.low_speed(low_speed),
		.suspend(suspend_q),
		.bus_reset_pulse(bus_reset_pulse),
		.resume_pulse(resume_pulse)
	);

	// APB handshake: zero wait, error on unmapped words
	assign mapped = reg_hit(paddr, uwa_pkg::FLAGS_IDX) || reg_hit(paddr, uwa_pkg::MASK_IDX) ||
		reg_hit(paddr, uwa_pkg::ADDR_IDX) || reg_hit(paddr, uwa_pkg::CTRL_IDX);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wr_en = psel && penable && pwrite && mapped;
	assign prdata = prdata_q;

	// External wake follows its two sources directly
	assign ext_bit = disk_irq_flag || gpio_irq_line;

	// Read view of every register
	always_comb begin
		rd_data = 32'h0000_0000;
		if (reg_hit(paddr, uwa_pkg::FLAGS_IDX)) begin
			rd_data[7:0] = {5'h00, flags_q, ext_bit};
		end else if (reg_hit(paddr, uwa_pkg::MASK_IDX)) begin
			rd_data[7:0] = uwa_pkg::MASK_FIXED | {5'h00, mask_q};
		end else if (reg_hit(paddr, uwa_pkg::ADDR_IDX)) begin
			rd_data[7:0] = uwa_pkg::ADDR_FIXED | {1'b0, addr_q};
		end else if (reg_hit(paddr, uwa_pkg::CTRL_IDX)) begin
			rd_data[uwa_pkg::CTRL_PD] = pd_q;
			rd_data[uwa_pkg::CTRL_SLEEP] = sleep_q;
			rd_data[uwa_pkg::CTRL_SUSPEND] = suspend_q;
			rd_data[uwa_pkg::CTRL_ADDR_EN] = addr_en_q;
			rd_data[uwa_pkg::CTRL_RING_ON] = osc.ring_en;
			rd_data[uwa_pkg::CTRL_XTAL_ON] = osc.xtal_en;
		end
	end

	// Read data captured in the setup cycle, stable through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_q <= rd_data;
		end
	end

	// Sticky flags: set events and write-one clears
	assign flag_set = {bus_reset_pulse, resume_pulse};
	assign flag_clr = (wr_en && reg_hit(paddr, uwa_pkg::FLAGS_IDX)) ? pwdata[2:1] : 2'b00;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= uwa_pkg::FLAGS_RESET[2:1];
		end else begin
			flags_q <= flag_set | (flags_q & ~flag_clr);
		end
	end

	// Wake mask, one means blocked
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= uwa_pkg::MASK_RESET[2:0];
		end else if (wr_en && reg_hit(paddr, uwa_pkg::MASK_IDX)) begin
			mask_q <= pwdata[2:0];
		end
	end

	// Enabled sources ORed onto the wake interrupt
	assign unmasked = {flags_q, ext_bit} & ~mask_q;
	assign mcu_wake_irq_input = |unmasked;

	// Bus address: engine loads, bus reset clears, software writes ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_q <= uwa_pkg::ADDR_RESET[6:0];
		end else if (bus_reset_pulse) begin
			addr_q <= 7'h00;
		end else if (addr_load.load) begin
			addr_q <= addr_load.value;
		end
	end

	// Token address compare, gated by the enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_q <= 1'b0;
		end else begin
			match_q <= addr_en_q && token_valid && (token_addr == addr_q);
		end
	end
	assign addr_match = match_q;

	// Control bits; power-down drops when a wake restarts the clocks
	assign wake_now = (clk_state_q == CLK_STOPPED) && mcu_wake_irq_input;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_q <= uwa_pkg::CTRL_RESET[uwa_pkg::CTRL_PD];
			sleep_q <= uwa_pkg::CTRL_RESET[uwa_pkg::CTRL_SLEEP];
			suspend_q <= uwa_pkg::CTRL_RESET[uwa_pkg::CTRL_SUSPEND];
			addr_en_q <= uwa_pkg::CTRL_RESET[uwa_pkg::CTRL_ADDR_EN];
		end else if (wake_now) begin
			pd_q <= 1'b0;
		end else if (wr_en && reg_hit(paddr, uwa_pkg::CTRL_IDX)) begin
			pd_q <= pwdata[uwa_pkg::CTRL_PD];
			sleep_q <= pwdata[uwa_pkg::CTRL_SLEEP];
			suspend_q <= pwdata[uwa_pkg::CTRL_SUSPEND];
			addr_en_q <= pwdata[uwa_pkg::CTRL_ADDR_EN];
		end
	end

	// Transceiver off while suspended
	assign xcvr_power_down = suspend_q;

	// Oscillator sequencer: ring off first, then all off, wake restarts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_state_q <= CLK_RUN;
		end else begin
			unique case (clk_state_q)
				CLK_RUN: begin
					if (sleep_q && pd_q) begin
						clk_state_q <= CLK_GATE_RING;
					end
				end
				CLK_GATE_RING: begin
					clk_state_q <= CLK_STOPPED;
				end
				CLK_STOPPED: begin
					if (mcu_wake_irq_input) begin
						clk_state_q <= CLK_RUN;
					end
				end
				default: begin
					clk_state_q <= CLK_RUN;
				end
			endcase
		end
	end

	// Enables decoded from the sequencer state
	assign osc.ring_en = (clk_state_q == CLK_RUN);
	assign osc.xtal_en = (clk_state_q != CLK_STOPPED);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_irq_or_mask: assert property (mcu_wake_irq_input ==
		((flags_q[2] && !mask_q[2]) || (flags_q[1] && !mask_q[1]) || (ext_bit && !mask_q[0])))
		else $error("wake interrupt differs from unmasked sources");
	a_flag_sticky: assert property (flags_q[1] && !flag_clr[1] |=> flags_q[1])
		else $error("resume flag dropped without a write-one");
	a_flag_clear: assert property (flag_clr[2] && !bus_reset_pulse |=> !flags_q[2])
		else $error("reset flag not cleared by a write-one");
	a_set_wins: assert property (bus_reset_pulse && flag_clr[2] |=> flags_q[2])
		else $error("bus reset event lost to a same-cycle clear");
	a_ext_read: assert property (psel && !penable && !pwrite &&
		reg_hit(paddr, uwa_pkg::FLAGS_IDX) |=> prdata[0] == $past(ext_bit))
		else $error("external wake bit read wrong");
	a_mask_ones: assert property (psel && !penable && !pwrite &&
		reg_hit(paddr, uwa_pkg::MASK_IDX) |=> prdata[7:3] == 5'h1f)
		else $error("mask upper bits not read as one");
	a_addr_top: assert property (psel && !penable && !pwrite &&
		reg_hit(paddr, uwa_pkg::ADDR_IDX) |=> prdata[7] && prdata[6:0] == $past(addr_q))
		else $error("address register read wrong");
	a_addr_clear: assert property (bus_reset_pulse |=> addr_q == 7'h00)
		else $error("bus reset did not clear the address");
	a_addr_ro: assert property (!bus_reset_pulse && !addr_load.load |=> $stable(addr_q))
		else $error("address changed without an engine load");
	a_addr_match: assert property (##1 addr_match ==
		($past(addr_en_q) && $past(token_valid) && $past(token_addr) == $past(addr_q)))
		else $error("address match wrong");
	a_sleep_seq: assert property (clk_state_q == CLK_RUN && sleep_q && pd_q |=>
		!osc.ring_en && osc.xtal_en ##1 !osc.xtal_en)
		else $error("oscillator stop order wrong");
	a_wake_restart: assert property (clk_state_q == CLK_STOPPED && mcu_wake_irq_input |=>
		osc.ring_en && osc.xtal_en && !pd_q)
		else $error("unmasked wake did not restart oscillators");
	a_xcvr_down: assert property (xcvr_power_down == suspend_q)
		else $error("transceiver power-down not following suspend");

	// Flag set checks for both sticky flags; hold for the reset flag, clear and set-wins for the resume flag
	a_reset_sets: assert property (bus_reset_pulse |=>
		flags_q[2])
		else $error("bus reset event did not set its flag");
	a_resume_sets: assert property (resume_pulse |=>
		flags_q[1])
		else $error("resume event did not set its flag");
	a_reset_sticky: assert property (flags_q[2] && !flag_clr[2] |=>
		flags_q[2])
		else $error("reset flag dropped without a write-one");
	a_resume_clear: assert property (flag_clr[1] && !resume_pulse |=>
		!flags_q[1])
		else $error("resume flag not cleared by a write-one");
	a_resume_wins: assert property (resume_pulse && flag_clr[1] |=>
		flags_q[1])
		else $error("resume event lost to a same-cycle clear");

	// Mask, address and match checks
	a_mask_write: assert property (wr_en && reg_hit(paddr, uwa_pkg::MASK_IDX) |=>
		mask_q == $past(pwdata[2:0]))
		else $error("mask write did not land");
	a_mask_block: assert property (mask_q == 3'h7 |->
		!mcu_wake_irq_input)
		else $error("wake interrupt raised with every source masked");
	a_addr_load: assert property (addr_load.load && !bus_reset_pulse |=>
		addr_q == $past(addr_load.value))
		else $error("engine address load did not land");
	a_match_gated: assert property (!addr_en_q |=>
		!addr_match)
		else $error("address match while disabled");

	// Oscillator order and hold checks
	a_ring_first: assert property ($fell(osc.xtal_en) |->
		!$past(osc.ring_en))
		else $error("crystal stopped before the ring oscillator");
	a_stop_holds: assert property (clk_state_q == CLK_STOPPED && !mcu_wake_irq_input |=>
		!osc.ring_en && !osc.xtal_en)
		else $error("oscillators restarted without a wake source");

	c_stop_and_wake: cover property (clk_state_q == CLK_STOPPED ##1 osc.ring_en);
	c_clear_flag: cover property (flags_q[2] ##1 flag_clr[2] ##1 !flags_q[2]);
	c_match: cover property (addr_match);
	c_slverr: cover property (pslverr);
endmodule

// ==== uwa_far_model.sv ====
/*
 Far-side model: bus line pair, external interrupt sources, address loads and tokens.
 Assumes the bench calls its tasks from one process; all outputs change after pclk rises.
*/
`timescale 1ns/1ps
module uwa_far_model (
	input wire logic pclk,
	output uwa_pkg::uwa_line_type line,
	output logic low_speed,
	output logic disk_irq_flag,
	output logic gpio_irq_line,
	output uwa_pkg::uwa_addr_load_type addr_load,
	output logic token_valid,
	output logic [6:0] token_addr,
	input wire logic addr_match
);
	// Idle: full-speed J, nothing pending
	initial begin
		line = 2'b10;
		low_speed = 1'b0;
		disk_irq_flag = 1'b0;
		gpio_irq_line = 1'b0;
		addr_load = '0;
		token_valid = 1'b0;
		token_addr = 7'h00;
	end

	// Both lines low for n sampled cycles, then J, then back to full speed
	task automatic se0(input int n, input logic ls);
		@(posedge pclk);
		low_speed <= ls;
		line <= 2'b00;
		repeat (n) @(posedge pclk);
		line <= ls ? 2'b01 : 2'b10;
		@(posedge pclk);
		low_speed <= 1'b0;
		line <= 2'b10;
	endtask

	// Host resume: K for three cycles; remote wakeup never starts here
	task automatic resume_k();
		@(posedge pclk);
		line <= 2'b01;
		repeat (3) @(posedge pclk);
		line <= 2'b10;
	endtask

	// Disk flag and GPIO line levels
	task automatic set_ext(input logic d, input logic g);
		@(posedge pclk);
		disk_irq_flag <= d;
		gpio_irq_line <= g;
	endtask

	// One-cycle address load from the engine
	task automatic load(input logic [6:0] v);
		@(posedge pclk);
		addr_load <= {1'b1, v};
		@(posedge pclk);
		addr_load <= '0;
	endtask

	// Token pulse; match taken one cycle later, address inverted once released
	task automatic token(input logic [6:0] a, output logic m);
		@(posedge pclk);
		token_valid <= 1'b1;
		token_addr <= a;
		@(posedge pclk);
		token_valid <= 1'b0;
		token_addr <= ~a;
		@(posedge pclk);
		m = addr_match;
	endtask
endmodule

// ==== usb_wakeup_and_address_test.sv ====
/*
 Self-checking bench for the wake-source and bus-address block over APB.
 Assumes the far-side model drives line, interrupt sources, loads and tokens.
*/
`timescale 1ns/1ps
module usb_wakeup_and_address_test;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [uwa_pkg::PADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready, pslverr, addr_match, irq, xpd, low_speed, disk, gpio, token_valid;
	logic [6:0] token_addr;
	uwa_pkg::uwa_line_type line;
	uwa_pkg::uwa_addr_load_type addr_load;
	uwa_pkg::uwa_osc_type osc;
	int n_errors = 0;
	int check_count = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic err, m;

	always #25 pclk = ~pclk;

	uwa_wake_ctrl u_uwa_wake_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .line(line),
		.low_speed(low_speed), .disk_irq_flag(disk), .gpio_irq_line(gpio),
		.addr_load(addr_load), .token_valid(token_valid), .token_addr(token_addr),
		.addr_match(addr_match), .mcu_wake_irq_input(irq), .osc(osc),
		.xcvr_power_down(xpd));

	uwa_far_model u_uwa_far_model (.pclk(pclk), .line(line), .low_speed(low_speed),
		.disk_irq_flag(disk), .gpio_irq_line(gpio), .addr_load(addr_load),
		.token_valid(token_valid), .token_addr(token_addr), .addr_match(addr_match));

	// Verdict and end of run
	task automatic conclude();
		if (n_errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// One APB transfer; result taken at the edge that sees pready
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] idx, input logic [7:0] exp, input string what);
		apb(1'b0, idx, 8'h00);
		chk(rd, {24'h0, exp}, what);
	endtask

	// Bounded wait for an oscillator state
	task automatic wait_osc(input logic [1:0] exp, input string what);
		int n;
		n = 0;
		while (osc !== exp && n < 8) begin
			@(posedge pclk);
			n++;
		end
		chk({30'h0, osc}, {30'h0, exp}, what);
	endtask

	// Hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			$display("mismatch at %0t: timeout", $time);
			conclude();
		end
	end

	// Main sequence
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rchk(uwa_pkg::FLAGS_IDX, 8'h00, "flags reset");
		rchk(uwa_pkg::MASK_IDX, 8'hff, "mask reset");
		rchk(uwa_pkg::ADDR_IDX, 8'h80, "addr reset");
		chk({30'h0, osc}, 32'h3, "osc reset");
		apb(1'b0, 8'h01, 8'h00);
		chk({31'h0, err}, 32'h1, "unmapped");
		apb(1'b1, uwa_pkg::MASK_IDX, 8'h00);
		rchk(uwa_pkg::MASK_IDX, 8'hf8, "mask fixed");
		u_uwa_far_model.set_ext(1'b1, 1'b0);
		rchk(uwa_pkg::FLAGS_IDX, 8'h01, "disk wake");
		chk({31'h0, irq}, 32'h1, "ext irq");
		apb(1'b1, uwa_pkg::FLAGS_IDX, 8'h01);
		rchk(uwa_pkg::FLAGS_IDX, 8'h01, "ext ro");
		apb(1'b1, uwa_pkg::MASK_IDX, 8'h01);
		@(posedge pclk);
		chk({31'h0, irq}, 32'h0, "ext masked");
		u_uwa_far_model.set_ext(1'b0, 1'b1);
		rchk(uwa_pkg::FLAGS_IDX, 8'h01, "gpio wake");
		u_uwa_far_model.set_ext(1'b0, 1'b0);
		rchk(uwa_pkg::FLAGS_IDX, 8'h00, "ext gone");
		u_uwa_far_model.load(7'h55);
		rchk(uwa_pkg::ADDR_IDX, 8'hd5, "loaded");
		apb(1'b1, uwa_pkg::ADDR_IDX, 8'h12);
		rchk(uwa_pkg::ADDR_IDX, 8'hd5, "addr ro");
		u_uwa_far_model.token(7'h55, m);
		chk({31'h0, m}, 32'h0, "match off");
		apb(1'b1, uwa_pkg::CTRL_IDX, 8'h08);
		u_uwa_far_model.token(7'h55, m);
		chk({31'h0, m}, 32'h1, "match on");
		u_uwa_far_model.token(7'h54, m);
		chk({31'h0, m}, 32'h0, "other addr");
		apb(1'b1, uwa_pkg::MASK_IDX, 8'hfb);
		u_uwa_far_model.se0(53, 1'b0);
		rchk(uwa_pkg::FLAGS_IDX, 8'h00, "se0 short");
		u_uwa_far_model.se0(54, 1'b0);
		rchk(uwa_pkg::FLAGS_IDX, 8'h04, "fs reset");
		chk({31'h0, irq}, 32'h1, "reset irq");
		rchk(uwa_pkg::ADDR_IDX, 8'h80, "addr cleared");
		apb(1'b1, uwa_pkg::FLAGS_IDX, 8'hfb);
		rchk(uwa_pkg::FLAGS_IDX, 8'h04, "zero keeps");
		apb(1'b1, uwa_pkg::FLAGS_IDX, 8'h04);
		rchk(uwa_pkg::FLAGS_IDX, 8'h00, "one clears");
		u_uwa_far_model.se0(54, 1'b1);
		rchk(uwa_pkg::FLAGS_IDX, 8'h04, "ls reset");
		apb(1'b1, uwa_pkg::FLAGS_IDX, 8'h04);
		// Write-one clear lands in the cycle of the bus reset event
		fork
			u_uwa_far_model.se0(54, 1'b0);
			begin
				repeat (52) @(posedge pclk);
				apb(1'b1, uwa_pkg::FLAGS_IDX, 8'h04);
			end
		join
		rchk(uwa_pkg::FLAGS_IDX, 8'h04, "set wins");
		apb(1'b1, uwa_pkg::FLAGS_IDX, 8'h04);
		apb(1'b1, uwa_pkg::MASK_IDX, 8'hfd);
		u_uwa_far_model.resume_k();
		rchk(uwa_pkg::FLAGS_IDX, 8'h00, "no suspend");
		apb(1'b1, uwa_pkg::CTRL_IDX, 8'h04);
		@(posedge pclk);
		chk({31'h0, xpd}, 32'h1, "xcvr down");
		u_uwa_far_model.resume_k();
		rchk(uwa_pkg::FLAGS_IDX, 8'h02, "resume");
		apb(1'b1, uwa_pkg::FLAGS_IDX, 8'h02);
		// Sleep with power-down: ring stops first, then all
		apb(1'b1, uwa_pkg::CTRL_IDX, 8'h07);
		repeat (8) if (osc === 2'b11) @(posedge pclk);
		chk({30'h0, osc}, 32'h1, "ring first");
		wait_osc(2'b00, "all stopped");
		u_uwa_far_model.resume_k();
		wait_osc(2'b11, "restart");
		rchk(uwa_pkg::CTRL_IDX, 8'h36, "pd cleared");
		conclude();
	end
endmodule
